// file: hdl/oim_top.sv
`timescale 1ns/1ps
// Function
// RULE1 - link sets pull-up, waits 50 ms, then samples id-grounded status
// RULE2 - id-grounded bit reads 0 for a cable, 1 when id floats
// RULE3 - grounded id means a-plug, floating id means b-plug
// RULE4 - with pull-up off, resistance code 000 ground up to 101 floating
// RULE5 - resistance code readable only in synchronous mode
// RULE6 - weak pull-up lets any valid resistor pull grounded comparator low
// RULE7 - pull-up control bit connects the 100k pull-up to id
// RULE8 - enabled open-detect change sends receive command with alt-int bit
// RULE9 - open comparator reads 1 floating, 0 for 102k or ground
// RULE10 - id-grounded state sits at bit 4 of interrupt status
// RULE11 - id-open state sits at bit 0 of carkit status
// RULE12 - enabled id-grounded edges raise an interrupt
// RULE13 - all supply comparator states readable from interrupt status; supply-valid reads 0 here while both its enables are clear
// RULE14 - session-ended goes 0 to 1 when supply drops below 0.5 V
// RULE15 - session-ended disabled and reads 0 when both enables clear
// RULE16 - link may clear pull-up and open enables to save current
// RULE17 - comparator outputs synchronised before status or edge logic
module oim_top (
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // analog comparator pins
   input  wire logic        cmp_id_grounded_i,
   input  wire logic        cmp_id_open_i,
   input  wire logic        cmp_supply_valid_i,
   input  wire logic        cmp_session_valid_i,
   input  wire logic        cmp_session_ended_i,
   input  wire logic [2:0]  rid_code_i,
   input  wire logic        sync_mode_i,
   // analog controls
   output logic             cable_id_pullup_on_o,
   output logic             session_end_cmp_en_o,
   output logic             open_cmp_en_o,
   // link event outputs
   output logic [7:0]       rxcmd_o,
   output logic             rxcmd_valid_o,
   output logic             irq_o
);

   // ----------------------------------------------------------------
   // input synchronisation
   // ----------------------------------------------------------------
   logic [4:0] cmp_sync;
   logic [2:0] rid_sync;
   logic       sync_mode_s;

   // every analog level is resynchronised to avoid metastable reads
   oim_sync #(.W(5)) u_cmp_sync (               // RULE17
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .d_i    ({cmp_id_grounded_i, cmp_session_ended_i, cmp_session_valid_i,
                cmp_supply_valid_i, cmp_id_open_i}),
      .q_o    (cmp_sync)
   );

   // the code is a slow static value; per-bit sync is acceptable here
   oim_sync #(.W(4)) u_rid_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .d_i    ({sync_mode_i, rid_code_i}),
      .q_o    ({sync_mode_s, rid_sync})
   );

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   logic       pullup_reg;
   logic [7:0] rise_en_reg;
   logic [7:0] fall_en_reg;
   logic [4:0] irq_stat_reg;
   logic [4:0] irq_mask_reg;
   logic [4:0] live;
   logic [4:0] prev_reg;
   logic [4:0] evt;
   logic       wr_en;
   logic       rd_en;
   logic       addr_ok;

   assign wr_en = psel_i & penable_i & pwrite_i & pready_o;
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;

   // decode helper used only by the error check; the read mux decodes on its own
   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == oim_pkg::OTG_CTRL_ADDR)   || (a == oim_pkg::INT_RISE_ADDR)  ||
                   (a == oim_pkg::INT_FALL_ADDR)   || (a == oim_pkg::INT_STATUS_ADDR) ||
                   (a == oim_pkg::CARKIT_ST_ADDR)  || (a == oim_pkg::RID_ADDR)       ||
                   (a == oim_pkg::IRQ_STAT_ADDR)   || (a == oim_pkg::IRQ_MASK_ADDR)  ||
                   (a == oim_pkg::RXCMD_ADDR);
   endfunction

   // a comparator is enabled while either its rising or its falling enable is set
   function automatic logic both_off(input int b);
      both_off = ~rise_en_reg[b] & ~fall_en_reg[b];
   endfunction

   assign addr_ok = known_addr(paddr_i);

   // pull-up control; the link owns the settle wait before sampling
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pullup_reg <= 1'b0;
      end else if (wr_en && paddr_i == oim_pkg::OTG_CTRL_ADDR) begin
         pullup_reg <= pwdata_i[oim_pkg::PULLUP_BIT]; // RULE7 RULE1 RULE16
      end
   end

   // edge enables; open-detect rides on bit 0 of the same registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rise_en_reg <= oim_pkg::EN_RESET;
         fall_en_reg <= oim_pkg::EN_RESET;
      end else if (wr_en) begin
         if (paddr_i == oim_pkg::INT_RISE_ADDR) begin
            rise_en_reg <= pwdata_i[7:0];
         end
         if (paddr_i == oim_pkg::INT_FALL_ADDR) begin
            fall_en_reg <= pwdata_i[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // live comparator view
   // ----------------------------------------------------------------
   // live bit order: 4 grounded, 3 ended, 2 session, 1 supply, 0 open.
   // id grounded reads 1 when floating (high through pull-up), 0 on a
   // cable or any valid resistor; the analog pin already carries that.
   always_comb begin
      live = cmp_sync;                                        // RULE2 RULE3 RULE6
      if (both_off(oim_pkg::SESSION_ENDED_BIT)) begin
         live[oim_pkg::SESSION_ENDED_BIT] = 1'b0;             // RULE15
      end
      if (both_off(oim_pkg::SUPPLY_VALID_BIT)) begin
         live[oim_pkg::SUPPLY_VALID_BIT] = 1'b0;
      end
   end

   // edge detection on synchronised state only
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= live;
      end
   end

   // map a live bit index onto its enable-register position
   function automatic int en_pos(input int i);
      en_pos = (i == 0) ? oim_pkg::ID_OPEN_BIT : i;
   endfunction

   always_comb begin
      evt = '0;
      for (int i = 0; i < oim_pkg::EVT_W; i++) begin
         evt[i] = (live[i] & ~prev_reg[i] & rise_en_reg[en_pos(i)]) |
                  (~live[i] & prev_reg[i] & fall_en_reg[en_pos(i)]); // RULE12 RULE14
      end
   end

   // ----------------------------------------------------------------
   // sticky events and interrupt
   // ----------------------------------------------------------------
   // set beats a same-cycle write-one clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_stat_reg <= oim_pkg::EVT_RESET;
      end else if (wr_en && paddr_i == oim_pkg::IRQ_STAT_ADDR) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata_i[4:0]) | evt;
      end else begin
         irq_stat_reg <= irq_stat_reg | evt;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_mask_reg <= '0;
      end else if (wr_en && paddr_i == oim_pkg::IRQ_MASK_ADDR) begin
         irq_mask_reg <= pwdata_i[4:0];
      end
   end

   // level interrupt; registered from the current status, so it lags the status by one cycle
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_reg & irq_mask_reg);             // RULE12
      end
   end

   // ----------------------------------------------------------------
   // receive command generation
   // ----------------------------------------------------------------
   // open-detect changes use the alternate-interrupt bit; every command carries the
   // supply and id levels in the low bits
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rxcmd_o       <= '0;
         rxcmd_valid_o <= 1'b0;
      end else begin
         rxcmd_valid_o <= |evt;
         if (|evt) begin
            rxcmd_o <= {evt[0], 2'b00, live[4:0]};              // RULE8
         end
      end
   end

   // analog enables follow the registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cable_id_pullup_on_o <= 1'b0;
         session_end_cmp_en_o <= 1'b1;
         open_cmp_en_o        <= 1'b1;
      end else begin
         cable_id_pullup_on_o <= pullup_reg;                                   // RULE7
         session_end_cmp_en_o <= ~both_off(oim_pkg::SESSION_ENDED_BIT);        // RULE15
         open_cmp_en_o        <= ~both_off(oim_pkg::ID_OPEN_BIT);              // RULE9
      end
   end

   // ----------------------------------------------------------------
   // apb read path
   // ----------------------------------------------------------------
   // no wait state: data registered in setup, pready in access
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~addr_ok;
         if (rd_en) begin
            prdata_o <= '0;
            unique case (paddr_i)
               oim_pkg::OTG_CTRL_ADDR:   prdata_o <= {31'h0, pullup_reg};
               oim_pkg::INT_RISE_ADDR:   prdata_o <= {24'h0, rise_en_reg};
               oim_pkg::INT_FALL_ADDR:   prdata_o <= {24'h0, fall_en_reg};
               oim_pkg::INT_STATUS_ADDR: prdata_o <= {27'h0, live[4:1], 1'b0}; // RULE10 RULE13
               oim_pkg::CARKIT_ST_ADDR:  prdata_o <= {31'h0, live[0]};         // RULE11 RULE9
               oim_pkg::RID_ADDR: begin
                  // only meaningful with pull-up off, in synchronous mode
                  if (sync_mode_s) begin
                     prdata_o <= {29'h0, rid_sync};                        // RULE4 RULE5
                  end
               end
               oim_pkg::IRQ_STAT_ADDR:   prdata_o <= {27'h0, irq_stat_reg};
               oim_pkg::IRQ_MASK_ADDR:   prdata_o <= {27'h0, irq_mask_reg};
               oim_pkg::RXCMD_ADDR:      prdata_o <= {24'h0, rxcmd_o};
               default:                  prdata_o <= '0;
            endcase
         end
      end
   end

endmodule

// file: pkg/oim_pkg.sv
package oim_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OTG_CTRL_ADDR   = 12'h000; // pull-up control
   localparam logic [11:0] INT_RISE_ADDR   = 12'h004; // rising-edge enables
   localparam logic [11:0] INT_FALL_ADDR   = 12'h008; // falling-edge enables
   localparam logic [11:0] INT_STATUS_ADDR = 12'h00c; // live comparator state
   localparam logic [11:0] CARKIT_ST_ADDR  = 12'h010; // open-detect state
   localparam logic [11:0] RID_ADDR        = 12'h014; // resistance code
   localparam logic [11:0] IRQ_STAT_ADDR   = 12'h018; // sticky events, w1c
   localparam logic [11:0] IRQ_MASK_ADDR   = 12'h01c; // irq mask
   localparam logic [11:0] RXCMD_ADDR      = 12'h020; // last receive command

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SUPPLY_VALID_BIT  = 1;
   localparam int SESSION_VALID_BIT = 2;
   localparam int SESSION_ENDED_BIT = 3;
   localparam int ID_GROUNDED_BIT   = 4;
   localparam int ID_OPEN_BIT       = 0; // carkit status and open enables
   localparam int PULLUP_BIT        = 0; // in control register
   localparam int ALT_INT_BIT       = 7; // receive command
   localparam int RID_W             = 3;
   localparam int EVT_W             = 5; // events: open,vbus,sess,end,gnd

   // ----------------------------------------------------------------
   // resistance codes and reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] RID_GROUND = 3'h0;
   localparam logic [2:0] RID_75     = 3'h1;
   localparam logic [2:0] RID_102K   = 3'h2;
   localparam logic [2:0] RID_200K   = 3'h3;
   localparam logic [2:0] RID_440K   = 3'h4;
   localparam logic [2:0] RID_FLOAT  = 3'h5;
   localparam logic [7:0] EN_RESET   = 8'h1f;
   localparam logic [4:0] EVT_RESET  = 5'h00;

   typedef enum logic [1:0] {
      OIM_BUS_SETUP  = 2'b01,
      OIM_BUS_ACCESS = 2'b10
   } oim_bus_e;

endpackage

// file: hdl/oim_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a vector of levels
module oim_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   // first stage is read only by the second
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= '0;
         q_o      <= '0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule

// file: verification/oim_monitor.sv
`timescale 1ns/1ps
module oim_monitor (
   input wire logic        clk_i, rstn_i, psel_i, penable_i, pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i, prdata_o,
   input wire logic        pready_o, pslverr_o, cmp_id_grounded_i, cmp_id_open_i,
   input wire logic        sync_mode_i, cable_id_pullup_on_o, session_end_cmp_en_o,
   input wire logic        open_cmp_en_o, rxcmd_valid_o,
   input wire logic [7:0]  rxcmd_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ----------------------------------------------------------------
   // pin ages, saturating so long quiet spans look alike
   // ----------------------------------------------------------------
   logic [3:0] gnd_age, open_age, mode_age;
   logic       gnd_q, open_q, mode_q, acc, rd, wctrl;
   function automatic logic [3:0] age(input logic c, input logic [3:0] a);
      return c ? 4'h0 : ((a == 4'hf) ? a : a + 4'h1);
   endfunction
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {gnd_age, open_age, mode_age, gnd_q, open_q, mode_q} <= '0;
      end else begin
         {gnd_q, open_q, mode_q} <= {cmp_id_grounded_i, cmp_id_open_i, sync_mode_i};
         gnd_age  <= age(gnd_q != cmp_id_grounded_i, gnd_age);
         open_age <= age(open_q != cmp_id_open_i, open_age);
         mode_age <= age(mode_q != sync_mode_i, mode_age);
      end
   end
   // completed transfers
   assign acc   = psel_i && penable_i && pready_o;
   assign rd    = acc && !pwrite_i;
   assign wctrl = acc && pwrite_i && paddr_i == oim_pkg::OTG_CTRL_ADDR;
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   property p_ready;      s_setup |=> pready_o; endproperty
   property p_ready_only; pready_o |-> psel_i && penable_i; endproperty
   property p_refuse;     pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
   // control bit lands at the access edge, the pin follows one edge later
   property p_pullup;     wctrl |-> ##2 cable_id_pullup_on_o == $past(pwdata_i[0], 2); endproperty
   property p_pullup_keep; $changed(cable_id_pullup_on_o) |-> $past(wctrl, 2); endproperty
   property p_open_evt;   rxcmd_valid_o && rxcmd_o[7] |-> open_age inside {[4'h1:4'h8]};
   endproperty
   property p_rid;
      rd && paddr_i == oim_pkg::RID_ADDR && !mode_q && mode_age > 4'h5 |-> prdata_o == 32'h0;
   endproperty
   property p_gnd;
      rd && paddr_i == oim_pkg::INT_STATUS_ADDR && gnd_age > 4'h5 |-> prdata_o[4] == gnd_q;
   endproperty
   property p_open;
      rd && paddr_i == oim_pkg::CARKIT_ST_ADDR && open_age > 4'h5 && open_cmp_en_o
         |-> prdata_o[0] == open_q;
   endproperty
   property p_end_off;
      rd && paddr_i == oim_pkg::INT_STATUS_ADDR && !session_end_cmp_en_o
         && !$past(session_end_cmp_en_o) |-> prdata_o[3] == 1'b0;
   endproperty
   a_ready:       assert property (p_ready) else $error("pready missing after setup");
   a_ready_only:  assert property (p_ready_only) else $error("pready outside access");
   a_refuse:      assert property (p_refuse) else $error("refused read with data");
   a_pullup:      assert property (p_pullup) else $error("pull-up not as written");
   a_pullup_keep: assert property (p_pullup_keep) else $error("pull-up moved");
   a_open_evt:    assert property (p_open_evt) else $error("alt bit without open change");
   a_rid:         assert property (p_rid) else $error("code outside sync mode");
   a_gnd:         assert property (p_gnd) else $error("grounded bit wrong");
   a_open:        assert property (p_open) else $error("open bit wrong");
   a_end_off:     assert property (p_end_off) else $error("ended bit while off");
endmodule
bind oim_top oim_monitor i_mon (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .cmp_id_grounded_i(cmp_id_grounded_i), .cmp_id_open_i(cmp_id_open_i),
   .sync_mode_i(sync_mode_i), .cable_id_pullup_on_o(cable_id_pullup_on_o),
   .session_end_cmp_en_o(session_end_cmp_en_o), .open_cmp_en_o(open_cmp_en_o),
   .rxcmd_valid_o(rxcmd_valid_o), .rxcmd_o(rxcmd_o));

// file: verification/oim_front_model.sv
`timescale 1ns/1ps
// id pin network and supply comparators; cable_i is the resistance code index
module oim_front_model #(
   parameter int SUPPLY_MV = 4400,
   parameter int SESS_MV   = 2000
) (
   input  wire logic [2:0]  cable_i,
   input  wire logic [15:0] supply_mv_i,
   input  wire logic        pullup_on_i, open_en_i, end_en_i,
   output logic             id_grounded_o, id_open_o, supply_valid_o,
   output logic             session_valid_o, session_ended_o,
   output logic [2:0]       rid_o
);
   // weak pull-up loses to any resistor, so only an open pin reads high
   assign id_grounded_o   = (cable_i == 3'h5);
   // open detect needs the strong pull-up and its enable
   assign id_open_o       = pullup_on_i && open_en_i && cable_i == 3'h5;
   assign rid_o           = cable_i;
   assign supply_valid_o  = supply_mv_i >= 16'(SUPPLY_MV);
   assign session_valid_o = supply_mv_i >= 16'(SESS_MV);
   assign session_ended_o = end_en_i && supply_mv_i < 16'd500;
endmodule

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
   logic        pwrite_i = 1'b0, sync_mode_i = 1'b1, err, pready_o, pslverr_o, irq_o;
   logic        gnd, opn, sv, ssv, se, pull, end_en, open_en, rxv;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic [2:0]  rid, cable = 3'h5;
   logic [7:0]  rxcmd_o;
   logic [15:0] mv = 16'd5000;
   int          err_count = 0, checks = 0;
   always #5 clk_i = ~clk_i;
   oim_top i_oim_top (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_id_grounded_i(gnd),
      .cmp_id_open_i(opn), .cmp_supply_valid_i(sv), .cmp_session_valid_i(ssv),
      .cmp_session_ended_i(se), .rid_code_i(rid), .sync_mode_i(sync_mode_i),
      .cable_id_pullup_on_o(pull), .session_end_cmp_en_o(end_en), .open_cmp_en_o(open_en),
      .rxcmd_o(rxcmd_o), .rxcmd_valid_o(rxv), .irq_o(irq_o));
   oim_front_model i_oim_front_model (.cable_i(cable), .supply_mv_i(mv), .pullup_on_i(pull),
      .open_en_i(open_en), .end_en_i(end_en), .id_grounded_o(gnd), .id_open_o(opn),
      .supply_valid_o(sv), .session_valid_o(ssv), .session_ended_o(se), .rid_o(rid));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // one transfer; ends one edge after release so the next setup never collides
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         report_and_stop();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      logic [11:0] a[5] = '{12'h000, 12'h004, 12'h008, 12'h01c, 12'h0fc};
      logic [31:0] e[5] = '{32'h0, 32'h1f, 32'h1f, 32'h0, 32'h0};
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, a[i], 32'h0);
         chk(rd, e[i]);
         chk({31'h0, err}, {31'h0, i == 4});
      end
      $display("t_regs done");
   endtask
   // the link waits 50 ms after the pull-up; here a few cycles settle the pins
   task automatic t_cable();
      apb(1'b1, oim_pkg::OTG_CTRL_ADDR, 32'h1);
      tick(1); // the pin is registered once more after the control bit
      chk({31'h0, pull}, 32'h1);
      cable <= 3'h0;
      tick(8);
      apb(1'b0, oim_pkg::INT_STATUS_ADDR, 32'h0);
      chk({31'h0, rd[4]}, 32'h0);
      cable <= 3'h5;
      tick(8);
      apb(1'b0, oim_pkg::INT_STATUS_ADDR, 32'h0);
      chk({31'h0, rd[4]}, 32'h1);
      $display("t_cable done");
   endtask
   task automatic t_open();
      int n;
      apb(1'b1, oim_pkg::IRQ_MASK_ADDR, 32'h1f);
      apb(1'b1, oim_pkg::IRQ_STAT_ADDR, 32'h1f);
      cable <= 3'h2;
      n = 0;
      while (!(rxv === 1'b1 && rxcmd_o[7] === 1'b1) && n < 20) begin
         @(posedge clk_i);
         n++;
      end
      chk({31'h0, n < 20}, 32'h1);
      if (n >= 20) begin
         err_count++;
         report_and_stop();
      end
      // live levels ride along: grounded 0, ended 0, session 1, supply 1, open 0
      chk({24'h0, rxcmd_o}, 32'h86);
      tick(2);
      chk({31'h0, irq_o}, 32'h1);
      apb(1'b0, oim_pkg::IRQ_STAT_ADDR, 32'h0);
      chk(rd, 32'h11);
      apb(1'b0, oim_pkg::CARKIT_ST_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, oim_pkg::IRQ_MASK_ADDR, 32'h0);
      apb(1'b1, oim_pkg::IRQ_STAT_ADDR, 32'h11);
      cable <= 3'h5;
      tick(8);
      chk({31'h0, irq_o}, 32'h0);
      apb(1'b0, oim_pkg::IRQ_STAT_ADDR, 32'h0);
      chk(rd, 32'h11);
      $display("t_open done");
   endtask
   task automatic t_rid();
      apb(1'b1, oim_pkg::OTG_CTRL_ADDR, 32'h0);
      for (int c = 0; c < 6; c++) begin
         cable <= 3'(c);
         tick(6);
         apb(1'b0, oim_pkg::RID_ADDR, 32'h0);
         chk(rd, 32'(c));
      end
      sync_mode_i <= 1'b0;
      tick(6);
      apb(1'b0, oim_pkg::RID_ADDR, 32'h0);
      chk(rd, 32'h0);
      sync_mode_i <= 1'b1;
      $display("t_rid done");
   endtask
   task automatic t_sess();
      apb(1'b0, oim_pkg::INT_STATUS_ADDR, 32'h0);
      chk({29'h0, rd[3:1]}, 32'h3);
      mv <= 16'd100;
      tick(8);
      apb(1'b0, oim_pkg::INT_STATUS_ADDR, 32'h0);
      chk({29'h0, rd[3:1]}, 32'h4);
      apb(1'b1, oim_pkg::INT_RISE_ADDR, 32'h17);
      apb(1'b1, oim_pkg::INT_FALL_ADDR, 32'h17);
      tick(4);
      chk({31'h0, end_en}, 32'h0);
      apb(1'b0, oim_pkg::INT_STATUS_ADDR, 32'h0);
      chk({31'h0, rd[3]}, 32'h0);
      $display("t_sess done");
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_cable();
      t_open();
      t_rid();
      t_sess();
      report_and_stop();
   end
endmodule
